// >>> design/power_mode_and_strobe_control.sv
// chip-level reset, clock phase, power mode and external strobe control
// assumes: core_clk_i is the oscillator input; cpu supplies fetch and data access phase requests
`timescale 1ns/100ps
`include "power_mode_regs.svh"

// Summary of operation
// RULE1 - reset after reset pin is high two machine cycles
// RULE2 - address latch strobe pulses at one sixth oscillator rate
// RULE3 - one address latch pulse dropped per external data access
// RULE4 - program fetch strobe stays high during internal execution
// RULE5 - external fetch strobes twice per cycle, two skipped per data access
// RULE6 - fetch select low means all code fetched externally
// RULE7 - with a lock bit programmed, fetch select latched during reset
// RULE8 - oscillator divided by two before clock generation
// RULE9 - idle stops cpu, peripherals run, ram and registers keep
// RULE10 - idle ends on enabled interrupt or hardware reset
// RULE11 - reset from idle allows two cycles, ram writes blocked, ports allowed
// RULE12 - strobes high in idle, low in power down, port states per mode
// RULE13 - power down stops oscillator, nothing executes after request
// RULE14 - only hardware reset leaves power down
// RULE15 - reset reloads registers, leaves on-chip ram alone
// RULE16 - outside party holds reset until oscillator stable
// RULE17 - port 3 bits carry serial, interrupt, timer, read and write functions
// RULE18 - address latch pin is program pulse input in programming mode
// RULE19 - port 2 gives high address or its register for data access
// RULE20 - reset input synchronised and counted before acting
module power_mode_and_strobe_control
	import power_mode_pkg::*;
#(
	parameter int OSC_PER_CYCLE = `OSC_PER_MACHINE_CYCLE
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic reset_pin_i,
	input wire logic external_fetch_select_i,
	input wire logic [1:0] lock_bits_i,
	input wire logic programming_mode_i,
	input wire logic ale_pin_i,
	input wire logic idle_request_i,
	input wire logic power_down_request_i,
	input wire logic enabled_interrupt_i,
	input wire logic data_access_i,
	input wire logic data_access_wide_i,
	input wire logic [7:0] data_addr_high_i,
	input wire logic [7:0] fetch_addr_high_i,
	input wire logic [7:0] port2_register_i,
	input wire logic port3_write_strobe_n_i,
	input wire logic port3_read_strobe_n_i,
	input wire logic serial_transmit_i,
	input wire logic [7:0] port3_register_i,
	input wire logic [7:0] port3_pin_i,
	output logic address_latch_strobe_o,
	output logic program_fetch_strobe_n_o,
	output logic program_pulse_input_o,
	output logic internal_reset_o,
	output logic cpu_run_o,
	output logic peripheral_run_o,
	output logic oscillator_run_o,
	output logic ram_write_allow_o,
	output logic port_write_allow_o,
	output logic sfr_reload_o,
	output logic fetch_external_o,
	output logic port0_float_o,
	output logic port2_drive_address_o,
	output logic [7:0] port2_out_o,
	output logic [7:0] port3_out_o,
	output logic serial_receive_o,
	output logic external_interrupt_zero_o,
	output logic external_interrupt_one_o,
	output logic timer_zero_input_o,
	output logic timer_one_input_o
);
	localparam int HOLD = `RESET_HOLD_MACHINE_CYCLES * OSC_PER_CYCLE;
	localparam int GRACE = `IDLE_RESET_GRACE_MACHINE_CYCLES * OSC_PER_CYCLE;
	localparam int PW = $clog2(OSC_PER_CYCLE);
	localparam int GW = $clog2(GRACE + 1);

	////////////////////////////////////////////////////////////////////////////////
	// reset input
	logic pin_reset;

	// RULE1 two machine cycle hold
	reset_filter #(
		.HOLD_CYCLES(HOLD)
	) u_reset_filter (
		.core_clk_i(core_clk_i),
		.reset_pin_i(reset_pin_i),
		.reset_o(pin_reset)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock phase
	logic half_q;
	logic [PW-1:0] phase_q;
	logic [PW-1:0] phase_d;
	logic phase_last;

	power_mode_type mode_q;
	power_mode_type mode_d;
	logic osc_on;

	assign osc_on = (mode_q != MODE_POWER_DOWN);
	assign phase_last = (phase_q == PW'(OSC_PER_CYCLE - 2));
	assign phase_d = phase_last ? '0 : phase_q + PW'(2);

	// RULE8 divide by two
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			half_q <= 1'b0;
		end else if (osc_on) begin
			half_q <= ~half_q;
		end
	end

	// states: phase counts oscillator periods in steps of two per divided tick
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			phase_q <= '0;
		end else if (osc_on && half_q) begin
			phase_q <= phase_d;
		end
	end

	// two strobe slots per machine cycle: first and second half
	logic slot_a;
	logic slot_b;
	logic cycle_end;
	assign slot_a = osc_on && half_q && (phase_q == PW'(0));
	assign slot_b = osc_on && half_q && (phase_q == PW'(OSC_PER_CYCLE / 2));
	assign cycle_end = osc_on && half_q && phase_last;

	////////////////////////////////////////////////////////////////////////////////
	// power modes
	logic [GW-1:0] grace_q;
	logic [GW-1:0] grace_d;
	logic grace_busy;
	logic held_reset_q;

	assign grace_busy = (grace_q != '0);
	assign grace_d = grace_busy ? grace_q - GW'(1) : grace_q;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_RUN: begin
				// RULE13 power down wins over idle
				if (power_down_request_i) begin
					mode_d = MODE_POWER_DOWN;
				end else if (idle_request_i) begin
					mode_d = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				// RULE10 interrupt or reset ends idle
				if (enabled_interrupt_i || pin_reset) begin
					mode_d = MODE_RUN;
				end
			end
			MODE_POWER_DOWN: begin
				// RULE14 reset only
				if (pin_reset) begin
					mode_d = MODE_RUN;
				end
			end
			default: begin
				mode_d = MODE_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mode_q <= MODE_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// RULE11 grace window after reset ends idle
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			grace_q <= '0;
		end else if (mode_q == MODE_IDLE && pin_reset) begin
			grace_q <= GW'(GRACE);
		end else begin
			grace_q <= grace_d;
		end
	end

	// internal reset waits out the grace window
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			held_reset_q <= 1'b0;
		end else begin
			// the grace end forces a reset even when the pin has already dropped
			held_reset_q <= (pin_reset && !grace_busy && !(mode_q == MODE_IDLE)) || (grace_q == GW'(1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fetch select
	logic fetch_latched_q;
	logic locked;
	logic fetch_ext;
	assign locked = |lock_bits_i;

	// RULE7 latched during reset; caught by clock, never by async load
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			fetch_latched_q <= 1'b0;
		end else if (pin_reset) begin
			fetch_latched_q <= !external_fetch_select_i;
		end
	end

	// RULE6 low select means external code
	// without a lock bit the live pin decides
	assign fetch_ext = locked ? fetch_latched_q : !external_fetch_select_i;

	////////////////////////////////////////////////////////////////////////////////
	// strobes
	logic access_q;
	logic ale_d;
	logic program_fetch_strobe_n_d;
	logic running;
	assign running = (mode_q == MODE_RUN) && !held_reset_q;

	// access spans the machine cycle in which it was flagged
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			access_q <= 1'b0;
		end else if (data_access_i) begin
			// set wins: a flag on the last clock carries into the next cycle
			access_q <= 1'b1;
		end else if (cycle_end) begin
			access_q <= 1'b0;
		end
	end

	always_comb begin
		ale_d = 1'b0;
		program_fetch_strobe_n_d = 1'b1;
		case (mode_q)
			MODE_IDLE: begin
				// RULE12 idle levels
				ale_d = `STROBE_IDLE_LEVEL;
				program_fetch_strobe_n_d = `STROBE_IDLE_LEVEL;
			end
			MODE_POWER_DOWN: begin
				ale_d = `STROBE_POWER_DOWN_LEVEL;
				program_fetch_strobe_n_d = `STROBE_POWER_DOWN_LEVEL;
			end
			default: begin
				// RULE2 RULE3 two pulses per cycle, second dropped on data access
				ale_d = running && (slot_a || (slot_b && !access_q));
				// RULE4 RULE5 external fetch only, both skipped on data access
				program_fetch_strobe_n_d = !(running && fetch_ext && (slot_a || slot_b) && !access_q);
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			address_latch_strobe_o <= 1'b0;
			program_fetch_strobe_n_o <= 1'b1;
			program_pulse_input_o <= 1'b0;
		end else begin
			address_latch_strobe_o <= ale_d;
			program_fetch_strobe_n_o <= program_fetch_strobe_n_d;
			// RULE18 pin doubles as program pulse
			program_pulse_input_o <= programming_mode_i & ale_pin_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode outputs
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			internal_reset_o <= 1'b1;
			cpu_run_o <= 1'b0;
			peripheral_run_o <= 1'b0;
			oscillator_run_o <= 1'b1;
			ram_write_allow_o <= 1'b0;
			port_write_allow_o <= 1'b0;
			sfr_reload_o <= 1'b1;
			fetch_external_o <= 1'b0;
		end else begin
			internal_reset_o <= held_reset_q;
			// RULE9 cpu stops, peripherals keep going
			// mode register drives these, so they move in step with the strobes
			cpu_run_o <= running;
			peripheral_run_o <= (mode_q != MODE_POWER_DOWN) && !held_reset_q;
			oscillator_run_o <= osc_on;
			// RULE11 ram guarded, ports open during grace
			ram_write_allow_o <= running && !grace_busy;
			port_write_allow_o <= running;
			// RULE15 registers reload, ram untouched
			sfr_reload_o <= held_reset_q;
			fetch_external_o <= fetch_ext;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ports
	logic [7:0] p2_d;
	logic p2_addr;
	// RULE19 wide pointer drives high byte
	assign p2_addr = (mode_q == MODE_RUN && (access_q ? data_access_wide_i : fetch_ext))
		|| (mode_q == MODE_IDLE && fetch_ext);
	assign p2_d = !p2_addr ? port2_register_i :
		(access_q ? data_addr_high_i : fetch_addr_high_i);

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			port0_float_o <= 1'b0;
			port2_drive_address_o <= 1'b0;
			port2_out_o <= 8'hFF;
			port3_out_o <= 8'hFF;
			serial_receive_o <= 1'b1;
			external_interrupt_zero_o <= 1'b1;
			external_interrupt_one_o <= 1'b1;
			timer_zero_input_o <= 1'b1;
			timer_one_input_o <= 1'b1;
		end else begin
			// RULE12 port 0 floats with external code in low-power modes
			port0_float_o <= (mode_q != MODE_RUN) && fetch_ext;
			port2_drive_address_o <= p2_addr;
			port2_out_o <= p2_d;
			// RULE17 port 3 alternate functions
			port3_out_o <= {port3_register_i[7] & port3_read_strobe_n_i,
				port3_register_i[6] & port3_write_strobe_n_i,
				port3_register_i[5:2],
				port3_register_i[1] & serial_transmit_i,
				port3_register_i[0]};
			serial_receive_o <= port3_pin_i[0];
			external_interrupt_zero_o <= port3_pin_i[2];
			external_interrupt_one_o <= port3_pin_i[3];
			timer_zero_input_o <= port3_pin_i[4];
			timer_one_input_o <= port3_pin_i[5];
		end
	end
endmodule

// >>> design/power_mode_pkg.sv
// types shared by the power mode and strobe control
// assumes: compiled before the design modules
package power_mode_pkg;
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_POWER_DOWN
	} power_mode_type;
endpackage

// >>> design/power_mode_regs.svh
// timing counts and pin-state constants for the power mode and strobe control
// assumes: included by bare name from design files
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH
`define OSC_PER_MACHINE_CYCLE 12
`define RESET_HOLD_MACHINE_CYCLES 2
`define IDLE_RESET_GRACE_MACHINE_CYCLES 2
`define STROBE_IDLE_LEVEL 1'b1
`define STROBE_POWER_DOWN_LEVEL 1'b0
`define LOCK_BIT_COUNT 2
`endif

// >>> design/reset_filter.sv
// reset input synchroniser and hold-time filter
// assumes: reset pin asynchronous to core_clk_i, oscillator running
`timescale 1ns/100ps
module reset_filter #(
	parameter int HOLD_CYCLES = 24
) (
	input wire logic core_clk_i,
	input wire logic reset_pin_i,
	output logic reset_o
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	logic sync1_q;
	logic sync2_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic hit;

	assign hit = (count_q == CW'(HOLD_CYCLES));
	assign count_d = !sync2_q ? '0 : (hit ? count_q : count_q + CW'(1));

	always_ff @(posedge core_clk_i) begin
		sync1_q <= reset_pin_i;
		sync2_q <= sync1_q;
	end

	// RULE20 count high samples
	always_ff @(posedge core_clk_i) begin
		count_q <= count_d;
		reset_o <= hit & sync2_q;
	end
endmodule

// >>> test/power_mode_and_strobe_control_bench.sv
// self-checking bench for the power mode and strobe control
// assumes: design, package and monitor compiled before this file
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module power_mode_and_strobe_control_bench;
	logic core_clk_i = 0, resetn_i = 0, reset_pin_i, external_fetch_select_i = 0, programming_mode_i = 0;
	logic ale_pin_i = 0, idle_request_i = 0, power_down_request_i = 0, enabled_interrupt_i = 0;
	logic data_access_i = 0, data_access_wide_i = 0, serial_transmit_i = 1, pin_go = 0;
	logic port3_write_strobe_n_i = 1, port3_read_strobe_n_i = 1;
	logic [1:0] lock_bits_i = 2'h0;
	logic [7:0] data_addr_high_i = 8'h12, fetch_addr_high_i = 8'h34, port2_register_i = 8'hA5, pin_hold = 8'h00;
	logic [7:0] port3_register_i = 8'hFF, port3_pin_i = 8'h5A, port2_out_o, port3_out_o;
	logic address_latch_strobe_o, program_fetch_strobe_n_o, program_pulse_input_o, internal_reset_o;
	logic cpu_run_o, peripheral_run_o, oscillator_run_o, ram_write_allow_o, port_write_allow_o, sfr_reload_o;
	logic fetch_external_o, port0_float_o, port2_drive_address_o, serial_receive_o, external_interrupt_zero_o;
	logic external_interrupt_one_o, timer_zero_input_o, timer_one_input_o;
	int bad_count = 0, cmp_count = 0;
	power_mode_and_strobe_control #(.OSC_PER_CYCLE(12)) i_power_mode_and_strobe_control (.*);
	reset_source_model i_reset_source_model (.core_clk_i(core_clk_i), .go_i(pin_go), .hold_i(pin_hold),
		.reset_pin_o(reset_pin_i));
	always #10 core_clk_i = ~core_clk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_for(ref logic s, input logic v, input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			#1;
			if (s === v) break;
		end
	endtask
	task automatic count(input int n, output int na, output int np);
		na = 0;
		np = 0;
		repeat (n) begin
			cyc(1);
			na += address_latch_strobe_o;
			np += !program_fetch_strobe_n_o;
		end
	endtask
	task automatic pin_reset(input logic [7:0] n);
		@(posedge core_clk_i);
		pin_go <= 1;
		pin_hold <= n;
		@(posedge core_clk_i);
		pin_go <= 0;
	endtask
	task automatic t_data();
		int na, np;
		wait_for(address_latch_strobe_o, 1'b1, 20);
		// flag lands on the cycle-end edge, so it covers one whole machine cycle
		cyc(8);
		@(posedge core_clk_i);
		data_access_i <= 1;
		{port3_read_strobe_n_i, port3_write_strobe_n_i} <= 2'h1;
		@(posedge core_clk_i);
		data_access_i <= 0;
		count(60, na, np);
		`CHK(na, 9)
		`CHK(np, 8)
		`CHK(port3_out_o[7:6], 2'h1)
		$display("t_data done");
	endtask
	task automatic t_ports();
		@(posedge core_clk_i);
		serial_transmit_i <= 0;
		programming_mode_i <= 1;
		ale_pin_i <= 1;
		cyc(3);
		`CHK({serial_receive_o, external_interrupt_zero_o, external_interrupt_one_o}, 3'h1)
		`CHK({timer_zero_input_o, timer_one_input_o, port3_out_o[1]}, 3'h4)
		`CHK(program_pulse_input_o, 1'b1)
		`CHK({port2_drive_address_o, port2_out_o}, 9'h134)
		@(posedge core_clk_i);
		data_access_i <= 1;
		@(posedge core_clk_i);
		data_access_i <= 0;
		cyc(1);
		`CHK({port2_drive_address_o, port2_out_o}, 9'h0A5)
		@(posedge core_clk_i);
		data_access_i <= 1;
		data_access_wide_i <= 1;
		@(posedge core_clk_i);
		data_access_i <= 0;
		cyc(1);
		`CHK({port2_drive_address_o, port2_out_o}, 9'h112)
		cyc(12);
		@(posedge core_clk_i);
		idle_request_i <= 1;
		@(posedge core_clk_i);
		idle_request_i <= 0;
		cyc(2);
		`CHK({port0_float_o, port2_drive_address_o, port2_out_o}, 10'h334)
		@(posedge core_clk_i);
		enabled_interrupt_i <= 1;
		@(posedge core_clk_i);
		enabled_interrupt_i <= 0;
		cyc(2);
		`CHK(cpu_run_o, 1'b1)
		$display("t_ports done");
	endtask
	task automatic t_strobes();
		int na, np;
		count(60, na, np);
		`CHK(na, 10)
		`CHK(np, 10)
		@(posedge core_clk_i);
		external_fetch_select_i <= 1;
		cyc(3);
		count(60, na, np);
		`CHK(na, 10)
		`CHK(np, 0)
		$display("t_strobes done");
	endtask
	task automatic t_idle();
		@(posedge core_clk_i);
		idle_request_i <= 1;
		@(posedge core_clk_i);
		idle_request_i <= 0;
		cyc(3);
		`CHK({address_latch_strobe_o, program_fetch_strobe_n_o}, 2'h3)
		`CHK({cpu_run_o, peripheral_run_o}, 2'h1)
		@(posedge core_clk_i);
		enabled_interrupt_i <= 1;
		@(posedge core_clk_i);
		enabled_interrupt_i <= 0;
		cyc(3);
		`CHK(cpu_run_o, 1'b1)
		@(posedge core_clk_i);
		idle_request_i <= 1;
		@(posedge core_clk_i);
		idle_request_i <= 0;
		pin_reset(8'd40);
		wait_for(cpu_run_o, 1'b1, 60);
		`CHK({cpu_run_o, ram_write_allow_o, port_write_allow_o}, 3'h5)
		wait_for(internal_reset_o, 1'b1, 40);
		`CHK(internal_reset_o, 1'b1)
		wait_for(internal_reset_o, 1'b0, 100);
		$display("t_idle done");
	endtask
	task automatic t_down();
		@(posedge core_clk_i);
		power_down_request_i <= 1;
		@(posedge core_clk_i);
		power_down_request_i <= 0;
		cyc(3);
		`CHK({address_latch_strobe_o, program_fetch_strobe_n_o, oscillator_run_o, cpu_run_o, peripheral_run_o}, 5'h00)
		`CHK({port0_float_o, port2_drive_address_o, port2_out_o}, 10'h0A5)
		@(posedge core_clk_i);
		enabled_interrupt_i <= 1;
		@(posedge core_clk_i);
		enabled_interrupt_i <= 0;
		cyc(5);
		`CHK(oscillator_run_o, 1'b0)
		pin_reset(8'd40);
		wait_for(internal_reset_o, 1'b1, 60);
		`CHK({internal_reset_o, sfr_reload_o}, 2'h3)
		wait_for(internal_reset_o, 1'b0, 100);
		`CHK(oscillator_run_o, 1'b1)
		$display("t_down done");
	endtask
	task automatic t_filter();
		pin_reset(8'd12);
		wait_for(internal_reset_o, 1'b1, 40);
		`CHK(internal_reset_o, 1'b0)
		@(posedge core_clk_i);
		lock_bits_i <= 2'h1;
		pin_reset(8'd40);
		wait_for(internal_reset_o, 1'b1, 60);
		`CHK(internal_reset_o, 1'b1)
		wait_for(internal_reset_o, 1'b0, 100);
		@(posedge core_clk_i);
		external_fetch_select_i <= 0;
		cyc(4);
		`CHK(fetch_external_o, 1'b0)
		$display("t_filter done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk_i);
		resetn_i <= 1;
		t_data();
		t_ports();
		t_strobes();
		t_idle();
		t_down();
		t_filter();
		print_verdict();
	end
	// tests need about 460 clocks
	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end
endmodule

// >>> test/power_mode_and_strobe_control_monitor.sv
// port assertions for the power mode and strobe control
// assumes: bound into every instance, one clock domain
`timescale 1ns/100ps
module power_mode_and_strobe_control_monitor #(
	parameter int OSC_PER_CYCLE = 12
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic reset_pin_i,
	input wire logic [7:0] port3_register_i,
	input wire logic port3_write_strobe_n_i,
	input wire logic port3_read_strobe_n_i,
	input wire logic data_access_i,
	input wire logic address_latch_strobe_o,
	input wire logic program_fetch_strobe_n_o,
	input wire logic internal_reset_o,
	input wire logic cpu_run_o,
	input wire logic peripheral_run_o,
	input wire logic oscillator_run_o,
	input wire logic ram_write_allow_o,
	input wire logic port_write_allow_o,
	input wire logic fetch_external_o,
	input wire logic [7:0] port3_out_o
);
	logic [5:0] high_q;
	logic [5:0] low_q;
	logic [5:0] last_q = 6'h00;
	// saturating run lengths of the pin level; last_q keeps the latest high run
	always_ff @(posedge core_clk_i) begin
		high_q <= reset_pin_i ? high_q + {5'h00, high_q != 6'h3F} : 6'h00;
		last_q <= (!reset_pin_i && high_q != 6'h00) ? high_q : last_q;
		low_q <= reset_pin_i ? 6'h00 : low_q + {5'h00, low_q != 6'h3F};
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////////
	a_idle_strobes: assert property (
		!cpu_run_o && peripheral_run_o && !internal_reset_o |-> address_latch_strobe_o && program_fetch_strobe_n_o)
		else $error("strobes not high in idle");
	a_down_strobes: assert property (
		!oscillator_run_o |-> !address_latch_strobe_o && !program_fetch_strobe_n_o && !cpu_run_o)
		else $error("strobes or cpu active in power down");
	a_down_held: assert property (
		!oscillator_run_o && low_q >= 6'h08 |=> !oscillator_run_o)
		else $error("power down left without pin reset");
	a_fetch_quiet: assert property (
		!fetch_external_o && $past(!fetch_external_o) && oscillator_run_o |-> program_fetch_strobe_n_o)
		else $error("fetch strobe active on internal code");
	a_fetch_with_latch: assert property (
		address_latch_strobe_o && cpu_run_o && fetch_external_o && $past(fetch_external_o)
		&& !$past(data_access_i, 2) && !$past(data_access_i, 3) |-> !program_fetch_strobe_n_o)
		else $error("fetch strobe missing beside latch strobe");
	a_latch_gap: assert property (
		address_latch_strobe_o && cpu_run_o |=> (!address_latch_strobe_o || !cpu_run_o) [*5])
		else $error("latch strobes closer than six clocks");
	a_latch_return: assert property (
		address_latch_strobe_o && cpu_run_o |-> ##[1:12] (address_latch_strobe_o || !oscillator_run_o || internal_reset_o))
		else $error("more than one latch strobe skipped");
	a_reset_hold: assert property (
		$rose(internal_reset_o) |-> high_q >= 6'(2 * OSC_PER_CYCLE) || last_q >= 6'(2 * OSC_PER_CYCLE))
		else $error("internal reset after short pin pulse");
	a_grace_ports: assert property (
		cpu_run_o && !ram_write_allow_o && !internal_reset_o |-> port_write_allow_o ##[1:30] internal_reset_o)
		else $error("grace window wrong");
	a_port3_strobes: assert property (
		$past(resetn_i) |=> port3_out_o[7:6] == $past({port3_read_strobe_n_i, port3_write_strobe_n_i} & port3_register_i[7:6]))
		else $error("port 3 strobe bits wrong");
endmodule
bind power_mode_and_strobe_control power_mode_and_strobe_control_monitor #(.OSC_PER_CYCLE(OSC_PER_CYCLE))
	i_power_mode_and_strobe_control_monitor (.*);

// >>> test/reset_source_model.sv
// reset source in front of the block: drives the reset pin high for a span
// assumes: go_i is a one-cycle request from the bench, hold_i in clocks
`timescale 1ns/100ps
module reset_source_model (
	input wire logic core_clk_i,
	input wire logic go_i,
	input wire logic [7:0] hold_i,
	output logic reset_pin_o
);
	logic [7:0] left_q = 8'h00;
	// pin held for the whole span
	always_ff @(posedge core_clk_i) begin
		if (go_i) begin
			left_q <= hold_i;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	assign reset_pin_o = (left_q != 8'h00);
endmodule
